//--- verilog/qeci_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef QECI_REGS_SVH
`define QECI_REGS_SVH

`define QECI_OFF_CTRL      8'h00
`define QECI_OFF_RES       8'h04
`define QECI_OFF_ZOFF      8'h08
`define QECI_OFF_ABSIDX    8'h0C
`define QECI_OFF_SCALE     8'h10
`define QECI_OFF_OUTPOS    8'h14
`define QECI_OFF_EXTPOS    8'h18
`define QECI_OFF_EXTREV    8'h1C
`define QECI_OFF_STATUS    8'h20

`define QECI_FMODE_LSB     0
`define QECI_SRC_LSB       4
`define QECI_DEC_LSB       8
`define QECI_DIR_BIT       12

`define QECI_RST_RES       16'h0000
`define QECI_RST_ZOFF      16'h0000
`define QECI_RST_ABSIDX    32'h0000_0000
`define QECI_RST_SCALE     16'h0001

`define QECI_CLK_MHZ       250
`define QECI_EDGE_GAP_NS   40
`define QECI_EDGE_GAP_CYC  ((`QECI_EDGE_GAP_NS * `QECI_CLK_MHZ + 999) / 1000)

`endif

//--- verilog/qeci_pkg.sv
// types shared by the position interface
package qeci_pkg;
  typedef enum logic [2:0] {
    QECI_FM_INPUT   = 3'h0,
    QECI_FM_OUT_REV = 3'h1,
    QECI_FM_OUT_ABS = 3'h2,
    QECI_FM_IN_QUAD = 3'h3,
    QECI_FM_IN_STEP = 3'h4,
    QECI_FM_IN_UPDN = 3'h5,
    QECI_FM_DUO_REV = 3'h6,
    QECI_FM_DUO_ABS = 3'h7
  } qeci_fmode_t;

  typedef enum logic [1:0] {
    QECI_SRC_NONE = 2'h0,
    QECI_SRC_EMU  = 2'h1,
    QECI_SRC_OPTO = 2'h2
  } qeci_src_t;

  typedef enum logic [1:0] {
    QECI_DEC_QUAD = 2'h0,
    QECI_DEC_STEP = 2'h1,
    QECI_DEC_UPDN = 2'h2
  } qeci_dec_t;
endpackage

//--- verilog/qeci_qdec.sv
// input decoder for quadrature, step/direction and up/down signals
`timescale 1ns/1ps
module qeci_qdec (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              enable_i,
  input  wire qeci_pkg::qeci_dec_t mode_i,
  input  wire logic              ch_a_i,
  input  wire logic              ch_b_i,
  output logic                   step_o,
  output logic                   up_o
);
  logic prev_a_r;
  logic prev_b_r;

  wire chg_a   = ch_a_i ^ prev_a_r;
  wire chg_b   = ch_b_i ^ prev_b_r;
  wire rise_a  = ch_a_i & ~prev_a_r;
  wire rise_b  = ch_b_i & ~prev_b_r;
  // both channels moving at once has no defined direction
  wire q_step  = chg_a ^ chg_b;
  wire q_up    = chg_a ? (ch_a_i ^ ch_b_i) : ~(ch_a_i ^ ch_b_i);
  // direction sampled with the step edge itself
  wire s_step  = rise_a;
  wire s_up    = ~ch_b_i;
  wire u_step  = rise_a ^ rise_b;
  wire u_up    = rise_a;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_a_r <= 1'b0;
      prev_b_r <= 1'b0;
    end else begin
      prev_a_r <= ch_a_i;
      prev_b_r <= ch_b_i;
    end
  end

  always_comb begin
    step_o = 1'b0;
    up_o   = 1'b0;
    unique case (mode_i)
      qeci_pkg::QECI_DEC_QUAD: begin
        step_o = q_step;
        up_o   = q_up;
      end
      qeci_pkg::QECI_DEC_STEP: begin
        step_o = s_step;
        up_o   = s_up;
      end
      qeci_pkg::QECI_DEC_UPDN: begin
        step_o = u_step;
        up_o   = u_up;
      end
      default: begin
        step_o = 1'b0;
        up_o   = 1'b0;
      end
    endcase
    step_o = step_o & enable_i;
  end
endmodule

//--- verilog/qeci_top.sv
// encoder emulation output and secondary position input
`timescale 1ns/1ps
`include "qeci_regs.svh"
module qeci_top (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic [15:0] fb_pos_i,
  input  wire logic        home_done_i,
  input  wire logic        emu_a_i,
  input  wire logic        emu_b_i,
  input  wire logic        emu_z_i,
  output logic             emu_a_o,
  output logic             emu_b_o,
  output logic             emu_z_o,
  output logic             emu_a_oe_o,
  output logic             emu_b_oe_o,
  output logic             emu_z_oe_o,
  input  wire logic        opto_a_i,
  input  wire logic        opto_b_i,
  output logic      [31:0] cmd_pos_o,
  output logic      [15:0] cmd_rev_o,
  output logic             cmd_step_o
);
  localparam logic [3:0] GAP_CYC = 4'(`QECI_EDGE_GAP_CYC);

  function automatic logic is_out_mode(input qeci_pkg::qeci_fmode_t m);
    is_out_mode = (m == qeci_pkg::QECI_FM_OUT_REV) ||
                  (m == qeci_pkg::QECI_FM_OUT_ABS) ||
                  (m == qeci_pkg::QECI_FM_DUO_REV) ||
                  (m == qeci_pkg::QECI_FM_DUO_ABS);
  endfunction

  function automatic logic is_abs_mode(input qeci_pkg::qeci_fmode_t m);
    is_abs_mode = (m == qeci_pkg::QECI_FM_OUT_ABS) ||
                  (m == qeci_pkg::QECI_FM_DUO_ABS);
  endfunction

  // settings
  qeci_pkg::qeci_fmode_t fmode_r;
  qeci_pkg::qeci_src_t   src_r;
  qeci_pkg::qeci_dec_t   dec_r;
  logic                  dir_r;
  logic [15:0]           res_r;
  logic [15:0]           zoff_r;
  logic [31:0]           abs_idx_r;
  logic [15:0]           scale_r;

  wire sel_ctrl   = reg_addr_i == `QECI_OFF_CTRL;
  wire sel_res    = reg_addr_i == `QECI_OFF_RES;
  wire sel_zoff   = reg_addr_i == `QECI_OFF_ZOFF;
  wire sel_absidx = reg_addr_i == `QECI_OFF_ABSIDX;
  wire sel_scale  = reg_addr_i == `QECI_OFF_SCALE;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fmode_r   <= qeci_pkg::QECI_FM_INPUT;
      src_r     <= qeci_pkg::QECI_SRC_NONE;
      dec_r     <= qeci_pkg::QECI_DEC_QUAD;
      dir_r     <= 1'b0;
      res_r     <= `QECI_RST_RES;
      zoff_r    <= `QECI_RST_ZOFF;
      abs_idx_r <= `QECI_RST_ABSIDX;
      scale_r   <= `QECI_RST_SCALE;
    end else if (reg_wr_i) begin
      if (sel_ctrl) begin
        fmode_r <= qeci_pkg::qeci_fmode_t'(reg_wdata_i[`QECI_FMODE_LSB +: 3]);
        src_r   <= qeci_pkg::qeci_src_t'(reg_wdata_i[`QECI_SRC_LSB +: 2]);
        dec_r   <= qeci_pkg::qeci_dec_t'(reg_wdata_i[`QECI_DEC_LSB +: 2]);
        dir_r   <= reg_wdata_i[`QECI_DIR_BIT];
      end
      if (sel_res)    res_r     <= reg_wdata_i[15:0];
      if (sel_zoff)   zoff_r    <= reg_wdata_i[15:0];
      if (sel_absidx) abs_idx_r <= reg_wdata_i;
      if (sel_scale)  scale_r   <= reg_wdata_i[15:0];
    end
  end

  // pin synchronisers
  wire  [4:0] pins_raw = {opto_b_i, opto_a_i, emu_z_i, emu_b_i, emu_a_i};
  logic [4:0] pins_s1_r;
  logic [4:0] pins_s2_r;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pins_s1_r[gi] <= 1'b0;
          pins_s2_r[gi] <= 1'b0;
        end else begin
          pins_s1_r[gi] <= pins_raw[gi];
          pins_s2_r[gi] <= pins_s1_r[gi];
        end
      end
    end
  endgenerate

  // emulated encoder output
  wire emit_en = is_out_mode(fmode_r);

  logic [1:0]         fb_top_r;
  logic signed [15:0] rev_r;
  logic [31:0]        out_pos_r;
  logic [15:0]        in_rev_r;
  logic [31:0]        abs_base_r;
  logic [3:0]         gap_r;

  wire [31:0] frac_prod = fb_pos_i * res_r;
  wire [15:0] frac_cnt  = frac_prod[31:16];
  wire wrap_up = (fb_top_r == 2'b11) && (fb_pos_i[15:14] == 2'b00);
  wire wrap_dn = (fb_top_r == 2'b00) && (fb_pos_i[15:14] == 2'b11);
  // new turn count used at once, no backward count at the wrap
  wire signed [15:0] rev_cur = wrap_up ? rev_r + 16'sh0001 :
                               wrap_dn ? rev_r - 16'sh0001 : rev_r;
  wire signed [32:0] rev_prod = rev_cur * $signed({1'b0, res_r});
  wire [31:0] target   = rev_prod[31:0] + {16'h0000, frac_cnt};
  wire signed [31:0] diff = $signed(target - out_pos_r);
  wire can_step  = emit_en && (gap_r == 4'h0);
  wire do_up     = can_step && (diff > 0);
  wire do_dn     = can_step && (diff < 0);
  wire [15:0] res_m1 = res_r - 16'h0001;
  // one phase state per count, four per line cycle
  wire [31:0] pos_nxt = do_up ? out_pos_r + 32'h0000_0001 :
                        do_dn ? out_pos_r - 32'h0000_0001 :
                        out_pos_r;
  wire [15:0] in_rev_nxt =
    do_up ? ((in_rev_r >= res_m1) ? 16'h0000 : in_rev_r + 16'h0001) :
    do_dn ? ((in_rev_r == 16'h0000) ? res_m1 : in_rev_r - 16'h0001) :
    in_rev_r;
  wire [1:0]  phase  = pos_nxt[1:0];
  wire qa = phase[1] ^ phase[0];
  wire qb = phase[1];
  wire [31:0] abs_rel = pos_nxt - abs_base_r;
  wire idx_rev = in_rev_nxt == zoff_r;
  wire idx_abs = abs_rel == abs_idx_r;
  wire idx_sel = is_abs_mode(fmode_r) ? idx_abs : idx_rev;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fb_top_r <= 2'b00;
      rev_r    <= 16'sh0000;
    end else begin
      fb_top_r <= fb_pos_i[15:14];
      rev_r    <= rev_cur;
    end
  end

  // output slews one count per gap, so large jumps catch up slowly
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_pos_r <= 32'h0000_0000;
      in_rev_r  <= 16'h0000;
      gap_r     <= 4'h0;
    end else begin
      out_pos_r <= pos_nxt;
      in_rev_r  <= in_rev_nxt;
      if (do_up || do_dn) gap_r <= GAP_CYC - 4'h1;
      else if (gap_r != 4'h0) gap_r <= gap_r - 4'h1;
    end
  end

  // homing moves the reference to the last zero point, no phase jump
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      abs_base_r <= 32'h0000_0000;
    end else if (home_done_i) begin
      abs_base_r <= out_pos_r - {16'h0000, in_rev_r};
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      emu_a_o    <= 1'b0;
      emu_b_o    <= 1'b0;
      emu_z_o    <= 1'b0;
      emu_a_oe_o <= 1'b0;
      emu_b_oe_o <= 1'b0;
      emu_z_oe_o <= 1'b0;
    end else begin
      emu_a_o    <= emit_en & (dir_r ? qb : qa);
      emu_b_o    <= emit_en & (dir_r ? qa : qb);
      emu_z_o    <= emit_en & idx_sel;
      emu_a_oe_o <= emit_en;
      emu_b_oe_o <= emit_en;
      emu_z_oe_o <= emit_en;
    end
  end

  // secondary input selection
  wire fm_in   = (fmode_r == qeci_pkg::QECI_FM_IN_QUAD) ||
                 (fmode_r == qeci_pkg::QECI_FM_IN_STEP) ||
                 (fmode_r == qeci_pkg::QECI_FM_IN_UPDN);
  wire fm_duo  = (fmode_r == qeci_pkg::QECI_FM_DUO_REV) ||
                 (fmode_r == qeci_pkg::QECI_FM_DUO_ABS);
  wire use_emu = fm_in ||
                 (!emit_en && (src_r == qeci_pkg::QECI_SRC_EMU));
  wire use_opt = fm_duo ||
                 (!fm_in && (src_r == qeci_pkg::QECI_SRC_OPTO));
  wire [1:0] fm_off = 2'(fmode_r - qeci_pkg::QECI_FM_IN_QUAD);
  // modes 3 to 5 pick the decoder directly
  wire qeci_pkg::qeci_dec_t eff_dec =
    fm_in  ? qeci_pkg::qeci_dec_t'(fm_off) :
    fm_duo ? qeci_pkg::QECI_DEC_STEP :
    dec_r;
  wire dec_en = (use_emu || use_opt) && (res_r != 16'h0000);
  wire dec_a  = use_opt ? pins_s2_r[3] : pins_s2_r[0];
  wire dec_b  = use_opt ? pins_s2_r[4] : pins_s2_r[1];
  logic dec_step;
  logic dec_up;

  qeci_qdec u_qdec (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .enable_i(dec_en),
    .mode_i  (eff_dec),
    .ch_a_i  (dec_a),
    .ch_b_i  (dec_b),
    .step_o  (dec_step),
    .up_o    (dec_up)
  );

  // scale assumed not above the resolution
  wire [15:0] amt = (eff_dec == qeci_pkg::QECI_DEC_STEP) ?
                    scale_r : 16'h0001;
  logic [15:0] ext_in_rev_r;
  wire  [16:0] up_sum = {1'b0, ext_in_rev_r} + {1'b0, amt};
  wire         up_wrap = up_sum >= {1'b0, res_r};
  wire  [16:0] up_val = up_wrap ? up_sum - {1'b0, res_r} : up_sum;
  wire         dn_wrap = ext_in_rev_r < amt;
  wire  [16:0] dn_val = {1'b0, ext_in_rev_r} + (dn_wrap ? {1'b0, res_r} :
                        17'h0_0000) - {1'b0, amt};

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_pos_o    <= 32'h0000_0000;
      cmd_rev_o    <= 16'h0000;
      ext_in_rev_r <= 16'h0000;
      cmd_step_o   <= 1'b0;
    end else begin
      cmd_step_o <= dec_step;
      if (dec_step && dec_up) begin
        cmd_pos_o    <= cmd_pos_o + {16'h0000, amt};
        ext_in_rev_r <= up_val[15:0];
        if (up_wrap) cmd_rev_o <= cmd_rev_o + 16'h0001;
      end else if (dec_step) begin
        cmd_pos_o    <= cmd_pos_o - {16'h0000, amt};
        ext_in_rev_r <= dn_val[15:0];
        if (dn_wrap) cmd_rev_o <= cmd_rev_o - 16'h0001;
      end
    end
  end

  // register reads
  wire [31:0] ctrl_rd = {19'h0_0000, dir_r, 2'b00, dec_r, 2'b00, src_r,
                         1'b0, fmode_r};
  wire [31:0] stat_rd = {26'h000_0000, emit_en, pins_s2_r};
  wire [31:0] rd_mux =
    sel_ctrl   ? ctrl_rd :
    sel_res    ? {16'h0000, res_r} :
    sel_zoff   ? {16'h0000, zoff_r} :
    sel_absidx ? abs_idx_r :
    sel_scale  ? {16'h0000, scale_r} :
    (reg_addr_i == `QECI_OFF_OUTPOS) ? out_pos_r - abs_base_r :
    (reg_addr_i == `QECI_OFF_EXTPOS) ? cmd_pos_o :
    (reg_addr_i == `QECI_OFF_EXTREV) ? {16'h0000, cmd_rev_o} :
    (reg_addr_i == `QECI_OFF_STATUS) ? stat_rd :
    32'h0000_0000;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) reg_rdata_o <= 32'h0000_0000;
    else          reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
  end

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence step_up_s;
    dec_step && dec_up;
  endsequence
  sequence step_dn_s;
    dec_step && !dec_up;
  endsequence

  no_drive_input_a: assert property (!emit_en |=> !emu_a_oe_o && !emu_z_oe_o)
    else $error("emulation pins driven in input mode");
  drive_output_a: assert property (emit_en |=> emu_a_oe_o && emu_b_oe_o)
    else $error("emulation pins not driven in output mode");
  // a direction swap or mode change may move both lines legally
  quad_single_a: assert property (
    ($past(dir_r) == $past(dir_r, 2)) &&
    ($past(emit_en) == $past(emit_en, 2)) |->
    !(emu_a_o != $past(emu_a_o) && emu_b_o != $past(emu_b_o)))
    else $error("A and B changed together");
  edge_gap_a: assert property ((do_up || do_dn) |=> !(do_up || do_dn)[*8])
    else $error("output counts too close");
  idx_abs_a: assert property (is_abs_mode(fmode_r) && idx_abs && emit_en
                              |=> emu_z_o)
    else $error("absolute index missing");
  home_ref_a: assert property (home_done_i |=>
                               out_pos_r - abs_base_r == {16'h0000, in_rev_r}
                               || $past(do_up || do_dn))
    else $error("home did not clear reference");
  res_zero_a: assert property (res_r == 16'h0000 |=> $stable(cmd_pos_o))
    else $error("command moved with zero resolution");
  src_none_a: assert property (!use_emu && !use_opt ##1 !use_emu && !use_opt
                               |-> $stable(cmd_pos_o))
    else $error("command moved with no source");
  step_up_a: assert property (step_up_s |=>
                              cmd_pos_o == $past(cmd_pos_o) + $past(amt))
    else $error("up step not scaled");
  step_dn_a: assert property (step_dn_s |=>
                              cmd_pos_o == $past(cmd_pos_o) - $past(amt))
    else $error("down step not scaled");
endmodule

//--- verification/qeci_ext_ctrl.sv
// behavioural external controller driving one connector's A/B lines
`timescale 1ns/1ps
module qeci_ext_ctrl (
  input  wire logic clock_i,
  output logic      a_o,
  output logic      b_o
);
  logic [1:0] ph;

  initial begin
    a_o = 1'b0;
    b_o = 1'b0;
  end

  // hold each level 4 cycles so both sync flops see it
  task automatic hold();
    repeat (4) @(posedge clock_i);
  endtask

  // resume from the current line levels, no phase jump
  task automatic quad(input int n, input bit up);
    ph = {b_o, a_o ^ b_o};
    for (int i = 0; i < n; i++) begin
      ph = up ? ph + 2'd1 : ph - 2'd1;
      a_o <= ph[1] ^ ph[0];
      b_o <= ph[1];
      hold();
    end
  endtask

  // both lines at once: no defined direction
  task automatic both();
    a_o <= !a_o;
    b_o <= !b_o;
    hold();
  endtask

  task automatic step(input int n, input bit up);
    a_o <= 1'b0;
    b_o <= !up;
    hold();
    for (int i = 0; i < n; i++) begin
      a_o <= 1'b1; // direction held around rising step
      hold();
      a_o <= 1'b0;
      hold();
    end
  endtask

  task automatic updn(input int n, input bit up);
    a_o <= 1'b0;
    b_o <= 1'b0;
    hold();
    for (int i = 0; i < n; i++) begin
      if (up) a_o <= 1'b1;
      else b_o <= 1'b1;
      hold();
      a_o <= 1'b0;
      b_o <= 1'b0;
      hold();
    end
  endtask
endmodule

//--- verification/qeci_tb.sv
// self-checking bench for the position interface
`timescale 1ns/1ps
`include "qeci_regs.svh"
module tb;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [15:0] fb_pos_i = 16'h0000;
  logic        home_done_i = 1'b0;
  logic        emu_a_o, emu_b_o, emu_z_o;
  logic        emu_a_oe_o, emu_b_oe_o, emu_z_oe_o;
  logic        ea, eb, oa, ob, emu_a_w, emu_b_w;
  logic [31:0] cmd_pos_o;
  logic [15:0] cmd_rev_o;
  logic        cmd_step_o;
  int          fail_count = 0;
  int          comparisons = 0;
  int          steps, edges, zrise;
  logic [1:0]  ab_q;
  logic        z_q;
  logic [31:0] p0, p1;

  always #2 clock_i = ~clock_i;
  // pin level: design wins while it drives
  assign emu_a_w = emu_a_oe_o ? emu_a_o : ea;
  assign emu_b_w = emu_b_oe_o ? emu_b_o : eb;

  qeci_ext_ctrl emu_ctl (.clock_i(clock_i), .a_o(ea), .b_o(eb));
  qeci_ext_ctrl opto_ctl (.clock_i(clock_i), .a_o(oa), .b_o(ob));

  qeci_top dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .fb_pos_i(fb_pos_i),
    .home_done_i(home_done_i), .emu_a_i(emu_a_w), .emu_b_i(emu_b_w),
    .emu_z_i(1'b0), .emu_a_o(emu_a_o), .emu_b_o(emu_b_o),
    .emu_z_o(emu_z_o), .emu_a_oe_o(emu_a_oe_o), .emu_b_oe_o(emu_b_oe_o),
    .emu_z_oe_o(emu_z_oe_o), .opto_a_i(oa), .opto_b_i(ob),
    .cmd_pos_o(cmd_pos_o), .cmd_rev_o(cmd_rev_o), .cmd_step_o(cmd_step_o));

  // event counters for step pulses, A/B changes and index rises
  always @(posedge clock_i) begin
    ab_q <= {emu_a_o, emu_b_o};
    z_q <= emu_z_o;
    if (cmd_step_o === 1'b1) steps++;
    if ({emu_a_o, emu_b_o} !== ab_q) edges++;
    if (emu_z_o === 1'b1 && z_q === 1'b0) zrise++;
  end

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    rd(`QECI_OFF_CTRL, d); chk("ctrl", 32'h0000_0000, d);
    rd(`QECI_OFF_RES, d); chk("res", 32'h0000_0000, d);
    rd(`QECI_OFF_SCALE, d); chk("scale", 32'h0000_0001, d);
    rd(`QECI_OFF_ABSIDX, d); chk("absidx", 32'h0000_0000, d);
    rd(8'h40, d); chk("unmapped", 32'h0000_0000, d);
    chk("oe", 32'h0000_0000, {emu_a_oe_o, emu_b_oe_o, emu_z_oe_o});
    $display("test reset done");
  endtask

  task automatic t_quad();
    logic [31:0] r0, r1;
    wr(`QECI_OFF_CTRL, 32'h0000_0003);
    rd(`QECI_OFF_EXTPOS, p0);
    emu_ctl.quad(4, 1'b1); settle(8);
    rd(`QECI_OFF_EXTPOS, p1); chk("res0 pos", p0, p1);
    wr(`QECI_OFF_RES, 32'h0000_0008);
    rd(`QECI_OFF_EXTREV, r0);
    emu_ctl.quad(8, 1'b1); settle(8);
    rd(`QECI_OFF_EXTPOS, p0); chk("quad up", p1 + 8, p0);
    rd(`QECI_OFF_EXTREV, r1); chk("quad rev", r0 + 1, r1);
    chk("rev port", r1, {16'h0000, cmd_rev_o});
    emu_ctl.quad(3, 1'b0); settle(8);
    rd(`QECI_OFF_EXTPOS, p1); chk("quad down", p0 - 3, p1);
    emu_ctl.both(); settle(8);
    rd(`QECI_OFF_EXTPOS, p0); chk("quad both", p1, p0);
    $display("test quadrature input done");
  endtask

  task automatic t_step();
    wr(`QECI_OFF_RES, 32'h0000_0064);
    wr(`QECI_OFF_SCALE, 32'h0000_0003);
    wr(`QECI_OFF_CTRL, 32'h0000_0004);
    rd(`QECI_OFF_EXTPOS, p0);
    steps = 0;
    emu_ctl.step(5, 1'b1);
    emu_ctl.step(2, 1'b0); settle(8);
    chk("step pulses", 32'd7, steps);
    chk("oe input", 32'h0000_0000, {emu_a_oe_o, emu_b_oe_o});
    rd(`QECI_OFF_EXTPOS, p1); chk("step pos", p0 + 9, p1);
    wr(`QECI_OFF_CTRL, 32'h0000_0005);
    emu_ctl.updn(3, 1'b1);
    emu_ctl.updn(1, 1'b0); settle(8);
    rd(`QECI_OFF_EXTPOS, p0); chk("updn pos", p1 + 2, p0);
    $display("test step and up-down input done");
  endtask

  task automatic t_source();
    wr(`QECI_OFF_CTRL, 32'h0000_0220); // opto source, up-down
    rd(`QECI_OFF_EXTPOS, p0);
    opto_ctl.updn(2, 1'b1); settle(8);
    rd(`QECI_OFF_EXTPOS, p1); chk("src opto", p0 + 2, p1);
    wr(`QECI_OFF_CTRL, 32'h0000_0000); // no source
    opto_ctl.quad(4, 1'b1); settle(8);
    rd(`QECI_OFF_EXTPOS, p0); chk("src none", p1, p0);
    wr(`QECI_OFF_CTRL, 32'h0000_0110); // emulation source, step
    emu_ctl.step(1, 1'b1); settle(8);
    rd(`QECI_OFF_EXTPOS, p1); chk("src emu", p0 + 3, p1);
    $display("test source select done");
  endtask

  task automatic t_emul();
    logic [31:0] d;
    wr(`QECI_OFF_RES, 32'h0000_0010);
    wr(`QECI_OFF_ZOFF, 32'h0000_0002);
    wr(`QECI_OFF_CTRL, 32'h0000_0001);
    fb_pos_i <= 16'h1000; settle(40);
    chk("a b fwd", 32'h0000_0002, {emu_a_o, emu_b_o});
    chk("oe out", 32'h0000_0007, {emu_a_oe_o, emu_b_oe_o, emu_z_oe_o});
    wr(`QECI_OFF_CTRL, 32'h0000_1001); settle(5);
    chk("a b swap", 32'h0000_0001, {emu_a_o, emu_b_o});
    edges = 0; zrise = 0;
    fb_pos_i <= 16'h4000; settle(80);
    chk("edges", 32'd3, edges);
    chk("rev index", 32'd1, zrise);
    rd(`QECI_OFF_OUTPOS, d); chk("out pos", 32'd4, d);
    wr(`QECI_OFF_ABSIDX, 32'h0000_0006);
    wr(`QECI_OFF_CTRL, 32'h0000_0002);
    zrise = 0;
    fb_pos_i <= 16'h6000; settle(60);
    fb_pos_i <= 16'hC000; settle(80);
    chk("abs index", 32'd1, zrise);
    edges = 0;
    fb_pos_i <= 16'h1000; settle(120);
    chk("wrap edges", 32'd5, edges);
    rd(`QECI_OFF_OUTPOS, d); chk("wrap pos", 32'd17, d);
    @(posedge clock_i) home_done_i <= 1'b1;
    @(posedge clock_i) home_done_i <= 1'b0;
    rd(`QECI_OFF_OUTPOS, d); chk("homed pos", 32'd1, d);
    $display("test emulated output done");
  endtask

  task automatic t_duo();
    for (int m = 6; m <= 7; m++) begin
      wr(`QECI_OFF_CTRL, m);
      rd(`QECI_OFF_EXTPOS, p0);
      opto_ctl.step(2, 1'b1); settle(8);
      rd(`QECI_OFF_EXTPOS, p1); chk("duo pos", p0 + 6, p1);
      chk("cmd port", p1, cmd_pos_o);
      chk("duo oe", 32'h0000_0003, {emu_a_oe_o, emu_b_oe_o});
    end
    $display("test dual modes done");
  endtask

  // reset in mid-run: settings and counts back to their reset state
  task automatic t_rst2();
    logic [31:0] d;
    @(posedge clock_i) rst_n_i <= 1'b0;
    settle(2);
    rst_n_i <= 1'b1;
    chk("cmd pos rst", 32'h0000_0000, cmd_pos_o);
    chk("oe rst", 32'h0000_0000, {emu_a_oe_o, emu_b_oe_o});
    rd(`QECI_OFF_CTRL, d); chk("ctrl rst", 32'h0000_0000, d);
    rd(`QECI_OFF_RES, d); chk("res rst", 32'h0000_0000, d);
    opto_ctl.step(1, 1'b1); settle(8);
    chk("cmd idle rst", 32'h0000_0000, cmd_pos_o);
    $display("test mid-run reset done");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // whole run needs about 850 cycles; the limit allows 50k cycles, about sixty times that
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end

  initial begin
    settle(4);
    rst_n_i <= 1'b1;
    t_reset();
    t_quad();
    t_step();
    t_source();
    t_emul();
    t_duo();
    t_rst2();
    end_of_test();
  end
endmodule
